// file: hdl/pidreg_regulator.sv
// Position regulator: PID terms, clipping stages and register slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Integral term is scaled accumulator times integral gain, divided by 8.
// - Accumulator is cut to an 8-bit window before multiplying.
// - Integral shift 0..11 divides by two to that power; 0 means none.
// - Derivative term is scaled error difference times gain, divided by 8.
// - Derivative difference divided by two to the shift 0..5 into 8 bits.
// - Integral term clipped by 8-bit limit on top magnitude bits.
// - Proportional term clipped by 8-bit limit on top magnitude bits.
// - Derivative term clipped by 8-bit limit on top magnitude bits.
// - 20-bit signed accumulator clipped symmetrically by its 8-bit limit.
// - Integrator input clipped by an 8-bit limit on top magnitude bits.
// - Summed output clipped to a 13-bit programmable magnitude.
// - Accumulator is a 20-bit signed value software can read and write.
// - Current error is encoder minus ramp position, 14-bit signed.
// - Previous error kept as 14-bit signed readable value.
// - Speed correction readable as 14-bit signed value.
// - Encoder speed readable as 14-bit signed value.
// - Error times proportional gain, divided by two to shift plus three; shift 0 means none.
// - Clipped output drives the pulse generator speed correction input.
// - Steps come from prescaled ramp ticks; each needs three clocks.
module pidreg_regulator
  import pidreg_pkg::*;
#(
  parameter int POS_W = 24
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write address channel
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  // Write response channel
  output var  logic [1:0]       s_axi_bresp,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // Read address channel
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  // Read data channel
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Motion inputs
  input  wire logic             ramp_tick,
  input  wire logic [POS_W-1:0] encoder_position,
  input  wire logic [POS_W-1:0] ramp_position,
  input  wire logic [13:0]      encoder_speed_in,
  // Pulse generator correction
  output var  logic [13:0]      speed_correction
);

  pidreg_state_t st;
  pidreg_state_t next_st;

  pidreg_val_t       e_raw;
  pidreg_val_t       prod_p;
  pidreg_val_t       sc_p;
  pidreg_val_t       in_c;
  pidreg_val_t       acc_n;
  pidreg_val_t       sc_i;
  pidreg_val_t       sc_d;
  pidreg_val_t       sum;
  logic [3:0]        ish;
  logic [2:0]        dsh;
  logic [31:0]       mask;
  logic [31:0]       wm;
  logic [31:0]       rd;
  logic              rd_ok;
  logic              wr_ok;
  logic              wr_go;
  logic              acc_wr;
  logic [7:0]        ar_idx;
  logic signed [POS_W-1:0] diff;

  always_comb begin
    next_st = st;
    e_raw   = '0;
    prod_p  = '0;
    sc_p    = '0;
    in_c    = '0;
    acc_n   = '0;
    sc_i    = '0;
    sc_d    = '0;
    sum     = '0;
    ish     = '0;
    dsh     = '0;
    mask    = '0;
    wm      = '0;
    rd      = '0;
    rd_ok   = 1'b0;
    wr_ok   = 1'b0;
    wr_go   = 1'b0;
    acc_wr  = 1'b0;
    ar_idx  = s_axi_araddr[9:2];
    diff    = $signed(encoder_position - ramp_position);

    next_st.enc_speed = $signed(encoder_speed_in);

    // Bus write: address and data taken in either order
    if (s_axi_awvalid && st.bus.awready) begin
      next_st.bus.have_aw = 1'b1;
      next_st.bus.aw_idx  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && st.bus.wready) begin
      next_st.bus.have_w = 1'b1;
      next_st.bus.wdata  = s_axi_wdata;
      next_st.bus.wstrb  = s_axi_wstrb;
    end
    if (st.bus.bvalid && s_axi_bready) begin
      next_st.bus.bvalid = 1'b0;
    end
    wr_go = st.bus.have_aw && st.bus.have_w && !st.bus.bvalid;
    for (int b = 0; b < 4; b++) begin
      mask[b*8 +: 8] = {8{st.bus.wstrb[b]}};
    end
    wm = st.bus.wdata & mask;
    if (wr_go) begin
      wr_ok = 1'b1;
      if (st.bus.aw_idx == IDX_CONTROL) begin
        if (mask[0]) next_st.cfg.presc_sel = wm[2:0];
      end else if (st.bus.aw_idx == IDX_PROP_GAIN) begin
        if (mask[0]) next_st.cfg.pgain = wm[7:0];
      end else if (st.bus.aw_idx == IDX_PROP_SHIFT) begin
        if (mask[0]) next_st.cfg.pshift = wm[2:0];
      end else if (st.bus.aw_idx == IDX_INT_GAIN) begin
        if (mask[0]) next_st.cfg.igain = wm[7:0];
      end else if (st.bus.aw_idx == IDX_INT_SHIFT) begin
        if (mask[0]) next_st.cfg.ishift = wm[3:0];
      end else if (st.bus.aw_idx == IDX_DER_GAIN) begin
        if (mask[0]) next_st.cfg.dgain = wm[7:0];
      end else if (st.bus.aw_idx == IDX_DER_SHIFT) begin
        if (mask[0]) next_st.cfg.dshift = wm[2:0];
      end else if (st.bus.aw_idx == IDX_LIM_INT) begin
        if (mask[0]) next_st.cfg.lim_i = wm[7:0];
      end else if (st.bus.aw_idx == IDX_LIM_PROP) begin
        if (mask[0]) next_st.cfg.lim_p = wm[7:0];
      end else if (st.bus.aw_idx == IDX_LIM_DER) begin
        if (mask[0]) next_st.cfg.lim_d = wm[7:0];
      end else if (st.bus.aw_idx == IDX_LIM_ACC) begin
        if (mask[0]) next_st.cfg.lim_acc = wm[7:0];
      end else if (st.bus.aw_idx == IDX_LIM_IN) begin
        if (mask[0]) next_st.cfg.lim_in = wm[7:0];
      end else if (st.bus.aw_idx == IDX_LIM_OUT) begin
        next_st.cfg.lim_out = (st.cfg.lim_out & ~mask[12:0]) | wm[12:0];
      end else if (st.bus.aw_idx == IDX_ACC) begin
        acc_wr = 1'b1;
      end else if (st.bus.aw_idx == IDX_CUR_ERR ||
                   st.bus.aw_idx == IDX_PRI_ERR ||
                   st.bus.aw_idx == IDX_CORR_OUT ||
                   st.bus.aw_idx == IDX_ENC_SPEED) begin
        wr_ok = 1'b1;
      end else begin
        wr_ok = 1'b0;
      end
      next_st.bus.bvalid  = 1'b1;
      next_st.bus.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      next_st.bus.have_aw = 1'b0;
      next_st.bus.have_w  = 1'b0;
    end
    next_st.bus.awready = !next_st.bus.have_aw && !next_st.bus.bvalid;
    next_st.bus.wready  = !next_st.bus.have_w && !next_st.bus.bvalid;

    // Bus read: one outstanding, answered the edge after the address
    if (st.bus.rvalid && s_axi_rready) begin
      next_st.bus.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.bus.arready) begin
      rd_ok = 1'b1;
      if (ar_idx == IDX_CONTROL) begin
        rd[2:0] = st.cfg.presc_sel;
      end else if (ar_idx == IDX_PROP_GAIN) begin
        rd[7:0] = st.cfg.pgain;
      end else if (ar_idx == IDX_PROP_SHIFT) begin
        rd[2:0] = st.cfg.pshift;
      end else if (ar_idx == IDX_INT_GAIN) begin
        rd[7:0] = st.cfg.igain;
      end else if (ar_idx == IDX_INT_SHIFT) begin
        rd[3:0] = st.cfg.ishift;
      end else if (ar_idx == IDX_DER_GAIN) begin
        rd[7:0] = st.cfg.dgain;
      end else if (ar_idx == IDX_DER_SHIFT) begin
        rd[2:0] = st.cfg.dshift;
      end else if (ar_idx == IDX_LIM_INT) begin
        rd[7:0] = st.cfg.lim_i;
      end else if (ar_idx == IDX_LIM_PROP) begin
        rd[7:0] = st.cfg.lim_p;
      end else if (ar_idx == IDX_LIM_DER) begin
        rd[7:0] = st.cfg.lim_d;
      end else if (ar_idx == IDX_LIM_ACC) begin
        rd[7:0] = st.cfg.lim_acc;
      end else if (ar_idx == IDX_LIM_IN) begin
        rd[7:0] = st.cfg.lim_in;
      end else if (ar_idx == IDX_LIM_OUT) begin
        rd[12:0] = st.cfg.lim_out;
      end else if (ar_idx == IDX_ACC) begin
        rd[19:0] = st.acc;
      end else if (ar_idx == IDX_CUR_ERR) begin
        rd[13:0] = st.err;
      end else if (ar_idx == IDX_PRI_ERR) begin
        rd[13:0] = st.prev;
      end else if (ar_idx == IDX_CORR_OUT) begin
        rd[13:0] = st.corr;
      end else if (ar_idx == IDX_ENC_SPEED) begin
        rd[13:0] = st.enc_speed;
      end else begin
        rd_ok = 1'b0;
      end
      next_st.bus.rvalid = 1'b1;
      next_st.bus.rdata  = rd;
      next_st.bus.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.bus.arready = !next_st.bus.rvalid;

    // Prescaler; a step that falls due while one is busy is dropped
    if (ramp_tick) begin
      if (st.presc_cnt + 7'h01 >= pidreg_div(st.cfg.presc_sel)) begin
        next_st.presc_cnt = '0;
        if (st.phase == ST_IDLE) next_st.phase = ST_ERR;
      end else begin
        next_st.presc_cnt = st.presc_cnt + 7'h01;
      end
    end

    ish = (st.cfg.ishift > INT_SHIFT_MAX) ? INT_SHIFT_MAX
                                          : st.cfg.ishift;
    dsh = (st.cfg.dshift > DER_SHIFT_MAX) ? DER_SHIFT_MAX
                                          : st.cfg.dshift;

    case (st.phase)
      ST_IDLE: begin
      end
      ST_ERR: begin
        e_raw = pidreg_clip(pidreg_val_t'(diff), MAX_ERR);
        next_st.err   = e_raw[13:0];
        next_st.phase = ST_TERMS;
      end
      ST_TERMS: begin
        // Proportional: multiply first keeps resolution
        prod_p = pidreg_val_t'(st.err) *
                 $signed({16'h0_000, st.cfg.pgain});
        sc_p = (st.cfg.pshift == 3'h0) ? prod_p
             : prod_p >>> (st.cfg.pshift + PROP_XTRA);
        sc_p = pidreg_clip(sc_p, MAX_TERM);
        sc_p = pidreg_clip(sc_p,
                 {11'h000, st.cfg.lim_p, 5'h00} >> 1);
        next_st.p_term = sc_p[12:0];

        // Integrator input and accumulator
        in_c = pidreg_clip(pidreg_val_t'(st.err),
                 {16'h0_000, st.cfg.lim_in} << SH_ERR);
        acc_n = pidreg_clip(pidreg_val_t'(st.acc) + in_c, MAX_ACC);
        acc_n = pidreg_clip(acc_n,
                 {16'h0_000, st.cfg.lim_acc} << SH_ACC);
        next_st.acc = acc_n[19:0];

        // Integral: divides before multiplying, from the held sum
        sc_i = pidreg_clip(pidreg_val_t'(st.acc) >>> ish,
                           MAX_S8);
        sc_i = (sc_i * $signed({16'h0_000, st.cfg.igain}))
               >>> GAIN_DIV;
        sc_i = pidreg_clip(sc_i,
                 {16'h0_000, st.cfg.lim_i} << SH_TERM);
        next_st.i_term = sc_i[12:0];

        // Derivative from the last two errors
        sc_d = pidreg_val_t'(st.err) - pidreg_val_t'(st.prev);
        sc_d = pidreg_clip(sc_d >>> dsh, MAX_S8);
        sc_d = (sc_d * $signed({16'h0_000, st.cfg.dgain}))
               >>> GAIN_DIV;
        sc_d = pidreg_clip(sc_d,
                 {16'h0_000, st.cfg.lim_d} << SH_TERM);
        next_st.d_term = sc_d[12:0];
        next_st.prev   = st.err;
        next_st.phase  = ST_SUM;
      end
      ST_SUM: begin
        sum = pidreg_val_t'(st.p_term) + pidreg_val_t'(st.i_term)
            + pidreg_val_t'(st.d_term);
        sum = pidreg_clip(sum, {11'h000, st.cfg.lim_out});
        next_st.corr  = sum[13:0];
        next_st.phase = ST_IDLE;
      end
      default: begin
        next_st.phase = ST_IDLE;
      end
    endcase

    // Software write to the accumulator wins over the update
    if (acc_wr) begin
      next_st.acc = $signed((st.acc & ~mask[19:0]) | wm[19:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                 <= '0;
      st.phase           <= ST_IDLE;
      st.cfg.pgain       <= RST_GAIN;
      st.cfg.igain       <= RST_GAIN;
      st.cfg.dgain       <= RST_GAIN;
      st.cfg.lim_i       <= RST_LIM;
      st.cfg.lim_p       <= RST_LIM;
      st.cfg.lim_d       <= RST_LIM;
      st.cfg.lim_acc     <= RST_LIM;
      st.cfg.lim_in      <= RST_LIM;
      st.cfg.lim_out     <= RST_LIMO;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready    = st.bus.awready;
  assign s_axi_wready     = st.bus.wready;
  assign s_axi_bvalid     = st.bus.bvalid;
  assign s_axi_bresp      = st.bus.bresp;
  assign s_axi_arready    = st.bus.arready;
  assign s_axi_rvalid     = st.bus.rvalid;
  assign s_axi_rresp      = st.bus.rresp;
  assign s_axi_rdata      = st.bus.rdata;
  assign speed_correction = st.corr;

endmodule : pidreg_regulator

`default_nettype wire

// file: common/pidreg_pkg.sv
// Package for the position regulator: register map, types, helpers
package pidreg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL     = 8'h00_A0;
  localparam logic [7:0] IDX_PROP_GAIN   = 8'h00_A4;
  localparam logic [7:0] IDX_PROP_SHIFT  = 8'h00_A5;
  localparam logic [7:0] IDX_INT_GAIN    = 8'h00_A8;
  localparam logic [7:0] IDX_INT_SHIFT   = 8'h00_A9;
  localparam logic [7:0] IDX_DER_GAIN    = 8'h00_AC;
  localparam logic [7:0] IDX_DER_SHIFT   = 8'h00_AD;
  localparam logic [7:0] IDX_LIM_INT     = 8'h00_B0;
  localparam logic [7:0] IDX_LIM_PROP    = 8'h00_B4;
  localparam logic [7:0] IDX_LIM_DER     = 8'h00_B8;
  localparam logic [7:0] IDX_LIM_ACC     = 8'h00_B9;
  localparam logic [7:0] IDX_LIM_IN      = 8'h00_BA;
  localparam logic [7:0] IDX_LIM_OUT     = 8'h00_BC;
  localparam logic [7:0] IDX_ACC         = 8'h00_C0;
  localparam logic [7:0] IDX_CUR_ERR     = 8'h00_C4;
  localparam logic [7:0] IDX_PRI_ERR     = 8'h00_C6;
  localparam logic [7:0] IDX_CORR_OUT    = 8'h00_C8;
  localparam logic [7:0] IDX_ENC_SPEED   = 8'h00_CA;

  // Field widths and limit alignment
  localparam int ERR_W     = 14;
  localparam int TERM_W    = 13;
  localparam int ACC_W     = 20;
  localparam int PROP_XTRA = 3;
  localparam int GAIN_DIV  = 3;
  localparam int SH_ERR    = 5;
  localparam int SH_TERM   = 4;
  localparam int SH_ACC    = 11;
  localparam logic [3:0] INT_SHIFT_MAX = 4'h0_00B;
  localparam logic [2:0] DER_SHIFT_MAX = 3'h5;
  localparam int PRESC_W   = 7;

  // Saturation bounds
  localparam logic [23:0] MAX_S8   = 24'h00_007F;
  localparam logic [23:0] MAX_TERM = 24'h00_0FFF;
  localparam logic [23:0] MAX_ERR  = 24'h00_1FFF;
  localparam logic [23:0] MAX_ACC  = 24'h07_FFFF;

  // Reset values
  localparam logic [7:0]  RST_GAIN  = 8'h00_00;
  localparam logic [7:0]  RST_LIM   = 8'h00_FF;
  localparam logic [12:0] RST_LIMO  = 13'h1F_FF;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic signed [23:0] pidreg_val_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERR,
    ST_TERMS,
    ST_SUM
  } pidreg_phase_t;

  typedef struct packed {
    logic [2:0]  presc_sel;
    logic [7:0]  pgain;
    logic [2:0]  pshift;
    logic [7:0]  igain;
    logic [3:0]  ishift;
    logic [7:0]  dgain;
    logic [2:0]  dshift;
    logic [7:0]  lim_i;
    logic [7:0]  lim_p;
    logic [7:0]  lim_d;
    logic [7:0]  lim_acc;
    logic [7:0]  lim_in;
    logic [12:0] lim_out;
  } pidreg_cfg_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        have_aw;
    logic        have_w;
    logic [7:0]  aw_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } pidreg_bus_t;

  typedef struct packed {
    pidreg_cfg_t         cfg;
    pidreg_bus_t         bus;
    pidreg_phase_t       phase;
    logic [PRESC_W-1:0]  presc_cnt;
    logic signed [13:0]  err;
    logic signed [13:0]  prev;
    logic signed [19:0]  acc;
    logic signed [12:0]  p_term;
    logic signed [12:0]  i_term;
    logic signed [12:0]  d_term;
    logic signed [13:0]  corr;
    logic signed [13:0]  enc_speed;
  } pidreg_state_t;

  // Symmetric clip to plus or minus bound
  function automatic pidreg_val_t pidreg_clip(input pidreg_val_t v,
                                              input logic [23:0] b);
    pidreg_val_t sb;
    sb = $signed(b);
    if (v > sb) return sb;
    else if (v < -sb) return -sb;
    return v;
  endfunction : pidreg_clip

  // Ramp ticks per regulator step
  function automatic logic [PRESC_W-1:0] pidreg_div(input logic [2:0] s);
    case (s)
      3'h0: return 7'h01;
      3'h1: return 7'h02;
      3'h2: return 7'h03;
      3'h3: return 7'h04;
      3'h4: return 7'h08;
      3'h5: return 7'h10;
      3'h6: return 7'h20;
      default: return 7'h40;
    endcase
  endfunction : pidreg_div

endpackage : pidreg_pkg

// file: test/pidreg_properties.sv
// Bus handshake, output timing and output range checks for the position regulator
`timescale 1ns/1ps
`default_nettype none
module pidreg_checker
  import pidreg_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Motion
  input wire logic        ramp_tick,
  input wire logic [13:0] speed_correction
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_data_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read data repeated");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_corr_timing: assert property ($changed(speed_correction) |->
    $past(ramp_tick, 3) || $past(ramp_tick, 4))
    else $error("correction moved without a regulator step");
  a_corr_range: assert property (speed_correction != 14'h2000)
    else $error("correction beyond the 13-bit bound");
endmodule : pidreg_checker

bind pidreg_regulator pidreg_checker u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .ramp_tick(ramp_tick),
  .speed_correction(speed_correction)
);
`default_nettype wire

// file: test/pidreg_motion_model.sv
// Ramp generator and encoder stand-in facing the regulator
`timescale 1ns/1ps
`default_nettype none
module pidreg_motion_model
  import pidreg_pkg::*;
#(
  parameter int POS_W = 24
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Bench control
  input  wire logic             tick_req,
  input  wire logic [13:0]      offset,
  // Regulator side
  output var  logic             ramp_tick,
  output var  logic [POS_W-1:0] encoder_position,
  output var  logic [POS_W-1:0] ramp_position,
  output var  logic [13:0]      encoder_speed_in
);
  // Ramp keeps moving so the error never comes from a parked axis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_tick     <= 1'b0;
      ramp_position <= POS_W'(16'h1000);
    end else begin
      ramp_tick <= tick_req;
      if (tick_req) ramp_position <= ramp_position + POS_W'(2'h3);
    end
  end
  assign encoder_position = ramp_position + POS_W'($signed(offset));
  assign encoder_speed_in = -offset;
endmodule : pidreg_motion_model
`default_nettype wire

// file: test/tb_pid_position_regulator.sv
// Self-checking bench for the position regulator
`timescale 1ns/1ps
`default_nettype none
module tb_pid_position_regulator
  import pidreg_pkg::*;
;
  logic        aclk, aresetn, tick_req, ramp_tick;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [23:0] enc_pos, ramp_pos;
  logic [13:0] enc_spd, corr, offset;
  int          err_total, comparisons;
  logic [7:0]  lims [5] = '{IDX_LIM_INT, IDX_LIM_PROP, IDX_LIM_DER,
                            IDX_LIM_ACC, IDX_LIM_IN};

  pidreg_regulator #(.POS_W(24)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ramp_tick(ramp_tick), .encoder_position(enc_pos),
    .ramp_position(ramp_pos), .encoder_speed_in(enc_spd),
    .speed_correction(corr)
  );

  pidreg_motion_model #(.POS_W(24)) u_far (
    .aclk(aclk), .aresetn(aresetn), .tick_req(tick_req), .offset(offset),
    .ramp_tick(ramp_tick), .encoder_position(enc_pos),
    .ramp_position(ramp_pos), .encoder_speed_in(enc_spd)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Response ready is offered with the request and held until the answer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] rsp = RESP_OKAY);
    @(posedge aclk);
    awaddr  <= {22'h0, idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, rsp});
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [1:0] rsp = RESP_OKAY);
    @(posedge aclk);
    araddr  <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, rsp});
  endtask : rd

  // One regulator step; spacing stays above ten clocks
  task automatic step(input logic [13:0] e, input logic [13:0] exp);
    @(posedge aclk);
    offset   <= e;
    tick_req <= 1'b1;
    @(posedge aclk);
    tick_req <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({18'h0, corr}, {18'h0, exp});
  endtask : step

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_sim();
  end

  initial begin
    {aresetn, tick_req, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    offset = 14'h0;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (lims[i]) rd(lims[i], 32'hFF);
    rd(IDX_LIM_OUT, 32'h1FFF);
    rd(IDX_ACC, 32'h0);
    rd(IDX_INT_GAIN, 32'h0);
    wr(IDX_INT_SHIFT, 32'hFFFF_FFFF);
    rd(IDX_INT_SHIFT, 32'hF);
    wr(IDX_DER_SHIFT, 32'hFFFF_FFFF);
    rd(IDX_DER_SHIFT, 32'h7);
    wr(IDX_ACC, 32'hFFFF_FFFF);
    rd(IDX_ACC, 32'hF_FFFF);
    wr(IDX_CUR_ERR, 32'h1234);
    rd(IDX_CUR_ERR, 32'h0);
    wr(8'h10, 32'h1, RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(IDX_INT_SHIFT, 32'h0);
    wr(IDX_DER_SHIFT, 32'h0);
    wr(IDX_ACC, 32'h0);
    $display("test registers done");
    wr(IDX_PROP_GAIN, 32'h80);
    wr(IDX_PROP_SHIFT, 32'h1);
    step(14'h0064, 14'h0320);
    rd(IDX_CUR_ERR, 32'h64);
    rd(IDX_CORR_OUT, 32'h320);
    wr(IDX_LIM_PROP, 32'h10);
    step(14'h0064, 14'h0100);
    wr(IDX_LIM_OUT, 32'h64);
    step(14'h3F9C, 14'h3F9C);
    rd(IDX_PRI_ERR, 32'h3F9C);
    wr(IDX_PROP_GAIN, 32'h0);
    wr(IDX_LIM_PROP, 32'hFF);
    wr(IDX_LIM_OUT, 32'h1FFF);
    $display("test proportional done");
    wr(IDX_INT_GAIN, 32'h8);
    wr(IDX_ACC, 32'h28);
    step(14'h0005, 14'h0028);
    wr(IDX_INT_SHIFT, 32'h2);
    step(14'h0005, 14'h000B);
    rd(IDX_ACC, 32'h32);
    wr(IDX_INT_SHIFT, 32'h0);
    wr(IDX_ACC, 32'h3E8);
    step(14'h0005, 14'h007F);
    wr(IDX_LIM_INT, 32'h1);
    step(14'h0005, 14'h0010);
    wr(IDX_LIM_IN, 32'h0);
    step(14'h0005, 14'h0010);
    rd(IDX_ACC, 32'h3F2);
    wr(IDX_LIM_ACC, 32'h0);
    step(14'h0005, 14'h0010);
    rd(IDX_ACC, 32'h0);
    wr(IDX_LIM_INT, 32'hFF);
    wr(IDX_LIM_IN, 32'hFF);
    wr(IDX_LIM_ACC, 32'hFF);
    wr(IDX_INT_SHIFT, 32'hB);
    wr(IDX_ACC, 32'h1_0000);
    step(14'h0005, 14'h0020);
    wr(IDX_INT_GAIN, 32'h0);
    $display("test integral done");
    wr(IDX_DER_GAIN, 32'h8);
    step(14'h0019, 14'h0014);
    rd(IDX_PRI_ERR, 32'h19);
    wr(IDX_DER_SHIFT, 32'h2);
    step(14'h002D, 14'h0005);
    wr(IDX_LIM_DER, 32'h0);
    step(14'h0041, 14'h0000);
    wr(IDX_LIM_DER, 32'hFF);
    wr(IDX_PROP_GAIN, 32'h80);
    wr(IDX_PROP_SHIFT, 32'h3);
    step(14'h0055, 14'h00AF);
    rd(IDX_ENC_SPEED, 32'h3FAB);
    rd(IDX_CORR_OUT, 32'hAF);
    $display("test derivative and sum done");
    end_sim();
  end
endmodule : tb_pid_position_regulator
`default_nettype wire
